// ### rtt_pkg.sv
// rtt_pkg: constants and types for the receive trail trace processor.
// assumes a single register clock; the framer hands trace bits on the same clock.
`default_nettype none
package rtt_pkg;
	// ***************************************************************
	// register map (byte addresses, one aligned word each)
	// ***************************************************************
	localparam int          ADDR_W        = 8;
	localparam logic [7:0]  ADDR_CTRL     = 8'h00;
	localparam logic [7:0]  ADDR_STATUS   = 8'h04;
	localparam logic [1:0]  REGION_CUR    = 2'h1;
	localparam logic [1:0]  REGION_ACC    = 2'h2;
	localparam logic [1:0]  REGION_EXP    = 2'h3;
	localparam int          CTRL_INVERT   = 0;
	localparam int          CTRL_ALIGN    = 1;
	localparam int          CTRL_CMP      = 2;
	localparam int          CTRL_REORDER  = 3;
	localparam logic [3:0]  CTRL_RESET    = 4'h6;
	localparam int          STAT_IDLE     = 0;
	localparam int          STAT_UNSTABLE = 1;
	localparam int          STAT_MISMATCH = 2;
	localparam int          STAT_CHANGE   = 3;
	localparam int          STAT_ALIGNED  = 4;
	localparam int          STAT_VALID    = 5;
	// ***************************************************************
	// identifier layout and decision counts
	// ***************************************************************
	localparam int          ID_BYTES      = 16;
	localparam logic [3:0]  LAST_IDX      = 4'hf;
	localparam logic [2:0]  LAST_BIT      = 3'h7;
	localparam logic [2:0]  STABLE_CNT    = 3'h5;
	localparam logic [3:0]  UNSTABLE_CNT  = 4'h8;
	localparam logic [7:0]  CMP_MASK_MSB  = 8'h7f;
	localparam logic [7:0]  CMP_MASK_LSB  = 8'hfe;
	// ***************************************************************
	// carriers
	// ***************************************************************
	typedef struct packed {
		logic              read;
		logic              write;
		logic [ADDR_W-1:0] address;
		logic [3:0]        byteenable;
		logic [31:0]       writedata;
	} rtt_av_req_t;
	typedef struct packed {
		logic valid;
		logic first;
		logic serial_trace_bits;
		logic los;
		logic lof;
		logic ais;
	} rtt_trace_in_t;
	typedef enum logic [1:0] {
		S_HUNT,
		S_CONFIRM,
		S_LOCK
	} rtt_state_t;
endpackage
`default_nettype wire

// ### rtt_rx_trace.sv
// rtt_rx_trace: receive trail trace processor with its four 16-byte identifier stores and
// an avalon-mm slave; framer bits and alarms arrive on the same clock.
`default_nettype none
module rtt_rx_trace (
	input  wire logic                   CLK_I,
	input  wire logic                   RST_B_I,
	input  wire logic                   CE_I,
	input  wire rtt_pkg::rtt_trace_in_t TRACE_I,
	input  wire rtt_pkg::rtt_av_req_t   AV_REQ_I,
	output logic                        AV_WAITREQUEST_O,
	output logic [31:0]                 AV_READDATA_O,
	output logic                        IDLE_O,
	output logic                        TRACE_UNSTABLE_COND_O,
	output logic                        TRACE_MISMATCH_COND_O,
	output logic                        CHANGE_O
);
	import rtt_pkg::*;

	// ***************************************************************
	// helpers
	// ***************************************************************
	function automatic logic [7:0] rev8(input logic [7:0] b);
		logic [7:0] r;
		r = '0;
		for (int i = 0; i < 8; i++) begin
			r[i] = b[7-i];
		end
		return r;
	endfunction

	function automatic logic [2:0] sat3(input logic [2:0] v);
		return (v == 3'h7) ? v : 3'(v + 3'h1);
	endfunction

	function automatic logic [3:0] sat4(input logic [3:0] v);
		return (v == 4'hf) ? v : 4'(v + 4'h1);
	endfunction

	// ***************************************************************
	// state
	// ***************************************************************
	logic [3:0]                  ctrl_q;
	logic                        wait_q;
	logic [31:0]                 rdata_q;
	logic [2:0]                  bit_cnt_q;
	logic [6:0]                  shift_q;
	logic [7:0]                  byte_q;
	logic                        byte_done_q;
	rtt_state_t                  st_q, st_d;
	logic [3:0]                  idx_q, idx_d;
	logic                        id_done_q, id_done_d;
	logic                        wr_en;
	logic [3:0]                  wr_idx;
	logic [ID_BYTES-1:0][7:0]    asm_q;
	logic [ID_BYTES-1:0][7:0]    cur_q;
	logic [ID_BYTES-1:0][7:0]    acc_q;
	logic [ID_BYTES-1:0][7:0]    exp_q;
	logic [2:0]                  rep_q;
	logic [2:0]                  zero_q;
	logic [3:0]                  mis_q;
	logic                        idle_q, unst_q, mism_q, chg_q, valid_q;

	// ***************************************************************
	// register bus decode
	// ***************************************************************
	wire        req      = AV_REQ_I.read | AV_REQ_I.write;
	wire        wr_take  = AV_REQ_I.write & ~wait_q & AV_REQ_I.byteenable[0];
	wire [1:0]  region   = AV_REQ_I.address[7:6];
	wire [3:0]  rd_idx   = AV_REQ_I.address[5:2];
	wire        hit_ctrl = AV_REQ_I.address == ADDR_CTRL;
	wire        hit_stat = AV_REQ_I.address == ADDR_STATUS;
	wire        al_bits  = AV_REQ_I.address[1:0] == 2'h0;
	wire        hit_exp  = (region == REGION_EXP) & al_bits;
	wire        invert   = ctrl_q[CTRL_INVERT];
	wire        align_en = ctrl_q[CTRL_ALIGN];
	wire        cmp_en   = ctrl_q[CTRL_CMP];
	wire        reorder  = ctrl_q[CTRL_REORDER];
	wire [7:0]  status   = {2'h0, valid_q, st_q == S_LOCK, chg_q, mism_q, unst_q, idle_q};
	wire [7:0]  mem_byte = (region == REGION_CUR) ? cur_q[rd_idx] :
	                       (region == REGION_ACC) ? acc_q[rd_idx] : exp_q[rd_idx];
	wire [31:0] rd_word  = hit_ctrl ? {28'h000_0000, ctrl_q} :
	                       hit_stat ? {24'h00_0000, status} :
	                       (region != 2'h0 && al_bits) ? {24'h00_0000, mem_byte} :
	                       32'h0000_0000;
	wire        clr_chg  = wr_take & hit_stat & AV_REQ_I.writedata[STAT_CHANGE];

	// ***************************************************************
	// avalon slave: one wait cycle, then waitrequest low for one cycle
	// ***************************************************************
	always_ff @(posedge CLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			wait_q  <= 1'b1;
			rdata_q <= 32'h0000_0000;
		end else if (CE_I) begin
			wait_q <= ~(req & wait_q);
			if (req & wait_q) begin
				rdata_q <= rd_word;
			end
		end
	end

	always_ff @(posedge CLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			ctrl_q <= CTRL_RESET;
			exp_q  <= '0;
		end else if (CE_I && wr_take) begin
			if (hit_ctrl) begin
				ctrl_q <= AV_REQ_I.writedata[3:0];
			end
			if (hit_exp) begin
				exp_q[rd_idx] <= AV_REQ_I.writedata[7:0];
			end
		end
	end

	// ***************************************************************
	// serial to parallel
	// ***************************************************************
	wire       alarm   = TRACE_I.los | TRACE_I.lof | TRACE_I.ais;
	wire       line_bt = alarm | (TRACE_I.serial_trace_bits ^ invert);
	wire [2:0] bit_pos = TRACE_I.first ? 3'h0 : bit_cnt_q;

	// first serial bit shifts to byte bit 7
	always_ff @(posedge CLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			bit_cnt_q   <= 3'h0;
			shift_q     <= 7'h00;
			byte_q      <= 8'h00;
			byte_done_q <= 1'b0;
		end else if (CE_I) begin
			byte_done_q <= TRACE_I.valid && bit_pos == LAST_BIT;
			if (TRACE_I.valid) begin
				shift_q   <= {shift_q[5:0], line_bt};
				bit_cnt_q <= 3'(bit_pos + 3'h1);
				if (bit_pos == LAST_BIT) begin
					byte_q <= {shift_q, line_bt};
				end
			end
		end
	end

	// ***************************************************************
	// alignment and extraction
	// ***************************************************************
	wire       multiframe_align_bit = byte_q[7];
	wire [7:0] rx_stored_trace_byte = reorder ? rev8(byte_q) : byte_q;

	always_comb begin
		st_d      = st_q;
		idx_d     = idx_q;
		wr_en     = 1'b0;
		wr_idx    = idx_q;
		id_done_d = 1'b0;
		if (byte_done_q) begin
			if (!align_en) begin
				wr_en     = 1'b1;
				idx_d     = 4'(idx_q + 4'h1);
				id_done_d = idx_q == LAST_IDX;
			end else begin
				case (st_q)
					S_HUNT: begin
						if (multiframe_align_bit) begin
							wr_en  = 1'b1;
							wr_idx = 4'h0;
							idx_d  = 4'h1;
							st_d   = S_CONFIRM;
						end
					end
					S_CONFIRM, S_LOCK: begin
						if ((idx_q == 4'h0) == multiframe_align_bit) begin
							wr_en     = 1'b1;
							idx_d     = 4'(idx_q + 4'h1);
							id_done_d = idx_q == LAST_IDX;
							if (idx_q == LAST_IDX) begin
								st_d = S_LOCK;
							end
						end else if (multiframe_align_bit) begin
							wr_en  = 1'b1;
							wr_idx = 4'h0;
							idx_d  = 4'h1;
							st_d   = S_CONFIRM;
						end else begin
							idx_d = 4'h0;
							st_d  = S_HUNT;
						end
					end
					default: begin
						st_d  = S_HUNT;
						idx_d = 4'h0;
					end
				endcase
			end
		end
	end

	// line-side writes need no bus activity
	always_ff @(posedge CLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			st_q      <= S_HUNT;
			idx_q     <= 4'h0;
			id_done_q <= 1'b0;
			asm_q     <= '0;
		end else if (CE_I) begin
			st_q      <= st_d;
			idx_q     <= idx_d;
			id_done_q <= id_done_d;
			if (wr_en) begin
				asm_q[wr_idx] <= rx_stored_trace_byte;
			end
		end
	end

	// ***************************************************************
	// identifier decisions
	// ***************************************************************
	wire       same_cur = asm_q == cur_q;
	wire       diff_acc = asm_q != acc_q;
	wire       nonzero  = |asm_q;
	wire [2:0] rep_nxt  = same_cur ? sat3(rep_q) : 3'h1;
	wire [2:0] zero_nxt = nonzero ? 3'h0 : sat3(zero_q);
	wire [3:0] mis_nxt  = (!same_cur && diff_acc) ? sat4(mis_q) : 4'h0;
	wire       stable5  = nonzero && rep_nxt >= STABLE_CNT;
	wire       upd      = id_done_q && stable5 && diff_acc;
	wire       idle_set = id_done_q && zero_nxt >= STABLE_CNT;
	wire       unst_set = id_done_q && mis_nxt >= UNSTABLE_CNT;
	wire       end_both = id_done_q && stable5;
	wire [7:0] cmp_mask = reorder ? CMP_MASK_LSB : CMP_MASK_MSB;
	wire       differ   = ((acc_q ^ exp_q) & {ID_BYTES{cmp_mask}}) != '0;

	always_ff @(posedge CLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			rep_q  <= 3'h0;
			zero_q <= 3'h0;
			mis_q  <= 4'h0;
			cur_q  <= '0;
		end else if (CE_I && id_done_q) begin
			rep_q  <= rep_nxt;
			zero_q <= zero_nxt;
			mis_q  <= mis_nxt;
			cur_q  <= asm_q;
		end
	end

	// accept and flag change, set beats clear
	always_ff @(posedge CLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			acc_q   <= '0;
			valid_q <= 1'b0;
			chg_q   <= 1'b0;
		end else if (CE_I) begin
			chg_q <= upd | (chg_q & ~clr_chg);
			if (upd) begin
				acc_q   <= asm_q;
				valid_q <= 1'b1;
			end
		end
	end

	always_ff @(posedge CLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			idle_q <= 1'b0;
			unst_q <= 1'b0;
			mism_q <= 1'b0;
		end else if (CE_I) begin
			idle_q <= !unst_set && (idle_set || (idle_q && !end_both));
			unst_q <= !idle_set && (unst_set || (unst_q && !end_both));
			mism_q <= cmp_en && align_en && valid_q && differ;
		end
	end

	assign AV_WAITREQUEST_O      = wait_q;
	assign AV_READDATA_O         = rdata_q;
	assign IDLE_O                = idle_q;
	assign TRACE_UNSTABLE_COND_O = unst_q;
	assign TRACE_MISMATCH_COND_O = mism_q;
	assign CHANGE_O              = chg_q;

	// ***************************************************************
	// assertions
	// ***************************************************************
	default clocking cb @(posedge CLK_I); endclocking
	default disable iff (!RST_B_I);

	property p_accept;
		(CE_I && upd) |=> (chg_q && valid_q && acc_q == $past(asm_q));
	endproperty
	a_accept: assert property (p_accept) else $error("accepted identifier not taken");

	property p_idle_rise;
		$rose(idle_q) |-> $past(id_done_q && !nonzero && zero_q == 3'h4);
	endproperty
	a_idle_rise: assert property (p_idle_rise) else $error("idle declared early");

	property p_idle_fall;
		$fell(idle_q) |-> $past(id_done_q && (stable5 || mis_nxt >= UNSTABLE_CNT));
	endproperty
	a_idle_fall: assert property (p_idle_fall) else $error("idle ended without cause");

	property p_unst_rise;
		$rose(unst_q) |-> $past(id_done_q && mis_q == 4'h7 && !same_cur && diff_acc);
	endproperty
	a_unst_rise: assert property (p_unst_rise) else $error("unstable declared early");

	property p_unst_fall;
		$fell(unst_q) |-> $past(id_done_q && (stable5 || !nonzero));
	endproperty
	a_unst_fall: assert property (p_unst_fall) else $error("unstable ended without cause");

	property p_no_mism_invalid;
		!valid_q |-> !mism_q;
	endproperty
	a_no_mism_invalid: assert property (p_no_mism_invalid) else $error("mismatch before valid");

	property p_align_off;
		(CE_I && !align_en) |=> !mism_q;
	endproperty
	a_align_off: assert property (p_align_off) else $error("mismatch with alignment off");

	property p_mism_track;
		(CE_I && cmp_en && align_en && valid_q && !differ) |=> !mism_q;
	endproperty
	a_mism_track: assert property (p_mism_track) else $error("mismatch on equal ids");

	property p_lock;
		$rose(st_q == S_LOCK) |-> $past(idx_q == LAST_IDX && !multiframe_align_bit);
	endproperty
	a_lock: assert property (p_lock) else $error("lock without fifteen zeros");

	property p_byte;
		(CE_I && TRACE_I.valid && bit_pos == LAST_BIT && alarm) |=> (byte_done_q && byte_q[0]);
	endproperty
	a_byte: assert property (p_byte) else $error("byte not handed over");

	property p_ack;
		(CE_I && req && wait_q) |=> !wait_q ##1 wait_q;
	endproperty
	a_ack: assert property (p_ack) else $error("bus answer timing wrong");
endmodule
`default_nettype wire

// ### rtt_framer_model.sv
// rtt_framer_model: stands in for the framer overhead extraction and
// serialises trace bytes onto the trace carrier, msb first.
// assumes one caller at a time, entering its tasks right after a rising edge.
`default_nettype none
module rtt_framer_model (
	input  wire logic                  clk_i,
	output var  rtt_pkg::rtt_trace_in_t trace_o
);
	timeunit 1ns;
	timeprecision 1ns;
	import rtt_pkg::*;

	logic [2:0] alarm;

	initial begin
		alarm   = 3'h0;
		trace_o = '0;
	end

	// ***************************************************************
	// serialiser
	// ***************************************************************
	task automatic quiet(input int n);
		for (int k = 0; k < n; k++) begin
			@(posedge clk_i);
			trace_o.valid             <= 1'b0;
			trace_o.first             <= 1'b0;
			// released line shows a pattern that changes every cycle
			trace_o.serial_trace_bits <= ~trace_o.serial_trace_bits;
		end
	endtask

	task automatic send_byte(input logic [7:0] b, input int gap);
		for (int k = 0; k < 8; k++) begin
			@(posedge clk_i);
			trace_o <= '{valid: 1'b1, first: (k == 0), serial_trace_bits: b[7-k],
				los: alarm[2], lof: alarm[1], ais: alarm[0]};
		end
		quiet(gap);
	endtask
endmodule
`default_nettype wire

// ### rx_trail_trace_processor_tb.sv
// rx_trail_trace_processor_tb: register-level tests of the receive trace block.
// assumes the framer model serialises bytes; software side is avalon-mm.
`default_nettype none
module rx_trail_trace_processor_tb;
	timeunit 1ns;
	timeprecision 1ns;
	import rtt_pkg::*;

	logic          clk;
	logic          rst_b;
	logic          ce;
	rtt_trace_in_t trace;
	rtt_av_req_t   av_req;
	logic          av_wait;
	logic [31:0]   av_rdata;
	logic          idle;
	logic          unst;
	logic          mism;
	logic          chg;
	logic [127:0]  id_a;
	logic [127:0]  id_b;
	int            bad_count;
	int            tests_run;

	rtt_rx_trace dut (
		.CLK_I(clk), .RST_B_I(rst_b), .CE_I(ce), .TRACE_I(trace), .AV_REQ_I(av_req),
		.AV_WAITREQUEST_O(av_wait), .AV_READDATA_O(av_rdata), .IDLE_O(idle),
		.TRACE_UNSTABLE_COND_O(unst), .TRACE_MISMATCH_COND_O(mism), .CHANGE_O(chg)
	);
	rtt_framer_model fr (.clk_i(clk), .trace_o(trace));

	initial clk = 1'b0;
	always #5 clk = ~clk;

	// ***************************************************************
	// helpers
	// ***************************************************************
	task automatic results;
		if (bad_count == 0 && tests_run > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			bad_count++;
			$display("unexpected %s: expected %h, seen %h", what, exp, seen);
		end
	endtask

	task automatic av_xfer(input logic w, input logic [7:0] a, input logic [31:0] wd,
		output logic [31:0] rd);
		@(posedge clk);
		av_req <= '{read: !w, write: w, address: a, byteenable: 4'hf, writedata: wd};
		// request held until the edge at which waitrequest is seen low
		@(posedge clk);
		while (av_wait !== 1'b0) @(posedge clk);
		rd = av_rdata;
		av_req <= '0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] t;
		av_xfer(1'b1, a, d, t);
	endtask

	task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] t;
		av_xfer(1'b0, a, 32'h0000_0000, t);
		chk(what, t, exp);
	endtask

	task automatic settle;
		repeat (2) @(posedge clk);
		#1;
	endtask

	function automatic logic [7:0] abyte(input int i);
		return id_a[127-8*i -: 8];
	endfunction

	function automatic logic [127:0] fill(input logic [7:0] b);
		return {16{b}};
	endfunction

	task automatic send_id(input logic [127:0] id, input int reps);
		for (int r = 0; r < reps; r++) begin
			for (int i = 0; i < 16; i++) fr.send_byte(id[127-8*i -: 8], i % 3);
		end
		fr.quiet(4);
		settle;
	endtask

	// ***************************************************************
	// tests
	// ***************************************************************
	initial begin
		rst_b     = 1'b0;
		ce        = 1'b1;
		av_req    = '0;
		bad_count = 0;
		tests_run = 0;
		for (int i = 0; i < 16; i++) id_a[127-8*i -: 8] = 8'h41 + 8'(i);
		id_a[127] = 1'b1;
		id_b = id_a;
		id_b[87:80] = 8'h7e;
		repeat (10) @(posedge clk);
		rst_b <= 1'b1;
		chk("waitrequest", 32'(av_wait), 32'h0000_0001);
		rd_chk("ctrl", ADDR_CTRL, 32'h0000_0006);
		rd_chk("status", ADDR_STATUS, 32'h0000_0000);
		wr(8'h10, 32'h0000_00a5);
		rd_chk("unmapped", 8'h10, 32'h0000_0000);
		rd_chk("current at reset", 8'h40, 32'h0000_0000);
		for (int i = 0; i < 16; i++) begin
			wr(8'hc0 + 8'(4 * i), 32'(abyte(i) ^ 8'h01));
		end
		rd_chk("expected 1", 8'hc4, 32'(abyte(1) ^ 8'h01));
		for (int k = 0; k < 3; k++) fr.send_byte(8'h35, 1);
		send_id(id_a, 2);
		chk("early mismatch", 32'(mism), 32'h0000_0000);
		chk("early change", 32'(chg), 32'h0000_0000);
		send_id(id_a, 5);
		chk("change", 32'(chg), 32'h0000_0001);
		rd_chk("status locked", ADDR_STATUS, 32'h0000_003c);
		for (int i = 0; i < 16; i++) begin
			rd_chk("accepted", 8'h80 + 8'(4 * i), 32'(abyte(i)));
		end
		rd_chk("current 0", 8'h40, 32'(abyte(0)));
		for (int i = 0; i < 16; i++) begin
			wr(8'hc0 + 8'(4 * i), 32'(abyte(i) ^ 8'h80));
		end
		settle;
		chk("mismatch masked", 32'(mism), 32'h0000_0000);
		wr(ADDR_STATUS, 32'h0000_0008);
		settle;
		chk("change cleared", 32'(chg), 32'h0000_0000);
		send_id(id_b, 4);
		send_id(id_a, 1);
		send_id(id_b, 4);
		chk("broken run", 32'(chg), 32'h0000_0000);
		rd_chk("accepted 5", 8'h94, 32'(abyte(5)));
		wr(8'hcc, 32'(abyte(3) ^ 8'h02));
		wr(ADDR_CTRL, 32'h0000_0002);
		settle;
		chk("compare off", 32'(mism), 32'h0000_0000);
		wr(ADDR_CTRL, 32'h0000_0006);
		settle;
		chk("compare on", 32'(mism), 32'h0000_0001);
		wr(ADDR_CTRL, 32'h0000_0005);
		settle;
		chk("align off", 32'(mism), 32'h0000_0000);
		send_id(~fill(8'h00), 5);
		chk("idle", 32'(idle), 32'h0000_0001);
		for (int k = 0; k < 8; k++) begin
			send_id(~fill(8'(k + 1)), 1);
			if (k == 6) chk("unstable at 7", 32'(unst), 32'h0000_0000);
		end
		chk("unstable", 32'(unst), 32'h0000_0001);
		chk("idle ended", 32'(idle), 32'h0000_0000);
		wr(ADDR_CTRL, 32'h0000_000d);
		send_id(~fill(8'h35), 5);
		chk("unstable ended", 32'(unst), 32'h0000_0000);
		chk("change again", 32'(chg), 32'h0000_0001);
		rd_chk("reordered", 8'h9c, 32'h0000_00ac);
		// clock enable low: zero identifiers must leave no trace
		@(posedge clk);
		ce <= 1'b0;
		send_id(~fill(8'h00), 5);
		chk("frozen idle", 32'(idle), 32'h0000_0000);
		@(posedge clk);
		ce <= 1'b1;
		for (int k = 0; k < 5; k++) begin
			fr.alarm = 3'h1 << (k % 3);
			send_id(fill(8'hff), 1);
		end
		fr.alarm = 3'h0;
		rd_chk("forced ones", 8'h80, 32'h0000_00ff);
		chk("no mismatch", 32'(mism), 32'h0000_0000);
		results;
	end

	initial begin
		#500_000;
		bad_count++;
		results;
	end
endmodule
`default_nettype wire
